/* sfcd_regs.svh */
`ifndef SFCD_REGS_SVH
`define SFCD_REGS_SVH
// opcodes used by the controller
`define SFCD_OP_WREN       8'h06
`define SFCD_OP_RD_VLOCK   8'he8
`define SFCD_OP_WR_VLOCK   8'he5
`define SFCD_OP_RD_NVLOCK  8'he2
`define SFCD_OP_WR_NVLOCK  8'he3
`define SFCD_OP_ER_NVLOCK  8'he4
`define SFCD_OP_RD_FREEZE  8'ha7
`define SFCD_OP_WR_FREEZE  8'ha6
`define SFCD_OP_WAKE       8'hab
`define SFCD_OP_BULK_A     8'hc7
`define SFCD_OP_BULK_B     8'h60
`define SFCD_OP_SUSPEND    8'h75
`define SFCD_OP_RESUME     8'h7a
`define SFCD_OP_RD_GPREG   8'h96
`define SFCD_OP_RD_DISC    8'h5a
`define SFCD_OP_FAST_RD    8'h0b
// frame shape constants
`define SFCD_ADDR3         3'h3
`define SFCD_ADDR4         3'h4
`define SFCD_FIXED_DUMMY   5'h08
`define SFCD_GPREG_LEN     7'h40
`define SFCD_LANES1        2'h0
`define SFCD_LANES2        2'h1
`define SFCD_LANES4        2'h2
`define SFCD_CLK_HALF      4'h2
`endif

/* sfcd_pkg.sv */
package sfcd_pkg;
  // protocol of the opcode phase
  typedef enum logic [1:0] {
    SFCD_PROTO_EXT  = 2'h0,
    SFCD_PROTO_DUAL = 2'h1,
    SFCD_PROTO_QUAD = 2'h2
  } sfcd_proto_t;
  // frame sequencer states, one-hot
  typedef enum logic [6:0] {
    SFCD_IDLE  = 7'h01,
    SFCD_WREN  = 7'h02,
    SFCD_GAP   = 7'h04,
    SFCD_OPC   = 7'h08,
    SFCD_ADR   = 7'h10,
    SFCD_DUM   = 7'h20,
    SFCD_DAT   = 7'h40
  } sfcd_state_t;
endpackage

/* sfcd_fifo.sv */
`timescale 1ns/100ps
// small synchronous fifo with valid/ready on both sides
module sfcd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } sfcd_fifo_st_t;
  sfcd_fifo_st_t     st_q, st_d;
  logic [WIDTH-1:0]  mem [DEPTH];
  logic              push, pop;

  // handshakes and flags
  assign in_ready  = (st_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_q.cnt != '0);
  assign out_data  = mem[st_q.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer and count update
  always_comb begin
    st_d = st_q;
    if (push) st_d.wp = (st_q.wp == AW'(DEPTH-1)) ? '0 : st_q.wp + 1'b1;
    if (pop) st_d.rp = (st_q.rp == AW'(DEPTH-1)) ? '0 : st_q.rp + 1'b1;
    st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (rst) st_q <= '0;
    else st_q <= st_d;
    if (push) mem[st_q.wp] <= in_data;
  end
endmodule // sfcd_fifo

/* sfcd_host.sv */
`timescale 1ns/100ps
`include "sfcd_regs.svh"
// Functional notes
// - opcode on 1/2/4 lanes per protocol; address/data lanes set per command
// - erase, lock and freeze writes get a separate write enable first
// - discovery-parameter read always has exactly 8 dummy clocks after address
// - general-purpose register read always has exactly 8 dummy clocks after opcode
// - E8h reads volatile lock bits: 3 address bytes, no dummy, stream
// - E5h writes volatile lock bits: 3 address bytes, no dummy, one byte
// - E2h reads nonvolatile lock bits: 4 address bytes, no dummy, stream
// - E3h sets nonvolatile lock bit: 4 address bytes, no data
// - E4h erases all nonvolatile lock bits: opcode only
// - A7h reads freeze bit: no address or dummy, single lane only
// - A6h sets freeze bit: opcode only, after write enable
// - ABh wakes from deep power-down: opcode only
module sfcd_host #(
  parameter int DEPTH = 32,
  parameter int CLK_HALF = 2
) (
  // system clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // link clock input (unused; this end makes sck from clk_sys)
  input  wire logic       clk_link,
  // user command
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic [7:0] cmd_opcode,
  input  wire logic [31:0] cmd_addr,
  input  wire logic [1:0] cmd_proto,
  input  wire logic [1:0] cmd_lanes,
  input  wire logic [4:0] cmd_dummy,
  input  wire logic [15:0] cmd_len,
  input  wire logic [7:0] cmd_wdata,
  // read data stream
  output logic            rd_valid,
  input  wire logic       rd_ready,
  output logic [7:0]      rd_data,
  output logic            busy,
  // flash pins
  output logic            sel_n,
  output logic            sck,
  output logic [3:0]      serial_data_lane_o,
  output logic [3:0]      serial_data_lane_oe,
  input  wire logic [3:0] serial_data_lane_i
);
  // frame shape decode of an opcode
  function automatic logic [2:0] fn_addr_bytes(input logic [7:0] op);
    case (op)
      `SFCD_OP_RD_VLOCK, `SFCD_OP_WR_VLOCK, `SFCD_OP_RD_DISC,
      `SFCD_OP_FAST_RD: fn_addr_bytes = `SFCD_ADDR3;
      `SFCD_OP_RD_NVLOCK, `SFCD_OP_WR_NVLOCK: fn_addr_bytes = `SFCD_ADDR4;
      default: fn_addr_bytes = 3'h0;
    endcase
  endfunction
  function automatic logic fn_is_read(input logic [7:0] op);
    case (op)
      `SFCD_OP_RD_VLOCK, `SFCD_OP_RD_NVLOCK, `SFCD_OP_RD_FREEZE,
      `SFCD_OP_RD_GPREG, `SFCD_OP_RD_DISC, `SFCD_OP_FAST_RD: fn_is_read = 1'b1;
      default: fn_is_read = 1'b0;
    endcase
  endfunction
  function automatic logic fn_needs_wren(input logic [7:0] op);
    case (op)
      `SFCD_OP_WR_VLOCK, `SFCD_OP_WR_NVLOCK, `SFCD_OP_ER_NVLOCK, `SFCD_OP_WR_FREEZE,
      `SFCD_OP_BULK_A, `SFCD_OP_BULK_B: fn_needs_wren = 1'b1;
      default: fn_needs_wren = 1'b0;
    endcase
  endfunction
  function automatic logic [4:0] fn_dummy(input logic [7:0] op, input logic [4:0] cfg);
    case (op)
      `SFCD_OP_RD_GPREG, `SFCD_OP_RD_DISC: fn_dummy = `SFCD_FIXED_DUMMY;
      `SFCD_OP_FAST_RD: fn_dummy = cfg;
      // lock, freeze and opcode-only frames carry no dummy clocks
      default: fn_dummy = 5'h00;
    endcase
  endfunction
  function automatic logic [2:0] fn_bits(input logic [1:0] l);
    fn_bits = (l == `SFCD_LANES4) ? 3'h4 : (l == `SFCD_LANES2) ? 3'h2 : 3'h1;
  endfunction

  // frame sequencer state; addr_q, the lane sync flops and the fifo are kept outside it
  typedef struct packed {
    sfcd_pkg::sfcd_state_t st;
    logic [7:0]  op;
    logic [31:0] sh;
    logic [2:0]  abytes;
    logic [1:0]  plane;
    logic [1:0]  dlane;
    logic [4:0]  dum;
    logic [15:0] len;
    logic [5:0]  bit_left;
    logic [7:0]  wdat;
    logic        rd;
    logic        sck;
    logic [3:0]  div;
    logic [7:0]  rx;
    logic [2:0]  rxn;
    logic        push;
    logic [7:0]  pdat;
  } sfcd_st_t;
  sfcd_st_t st_q, st_d;
  // link pins sampled through two flops
  logic [3:0] lane_s1_q, lane_s2_q;
  logic       fifo_ready;
  logic       rise, fall;
  logic [2:0] nb;
  logic [31:0] addr_q;

  always_ff @(posedge clk_sys) begin
    lane_s1_q <= serial_data_lane_i;
    lane_s2_q <= lane_s1_q;
  end

  // this end makes the serial clock from clk_sys; clk_link is unused
  assign rise = (st_q.div == 4'(CLK_HALF - 1)) && !st_q.sck;
  assign fall = (st_q.div == 4'(CLK_HALF - 1)) && st_q.sck;
  assign nb   = fn_bits((st_q.st == sfcd_pkg::SFCD_OPC || st_q.st == sfcd_pkg::SFCD_WREN) ?
                        st_q.plane : st_q.dlane);
  assign cmd_ready = (st_q.st == sfcd_pkg::SFCD_IDLE);
  assign busy      = !cmd_ready;
  assign sel_n     = (st_q.st == sfcd_pkg::SFCD_IDLE) || (st_q.st == sfcd_pkg::SFCD_GAP);
  assign sck       = st_q.sck;
  // drive lanes from the top of the shift register
  always_comb begin
    serial_data_lane_o  = 4'h0;
    serial_data_lane_oe = 4'h0;
    case (nb)
      3'h4: serial_data_lane_o = st_q.sh[31:28];
      3'h2: serial_data_lane_o = {2'h0, st_q.sh[31:30]};
      default: serial_data_lane_o = {3'h0, st_q.sh[31]};
    endcase
    if (!sel_n && st_q.st != sfcd_pkg::SFCD_DUM && st_q.st != sfcd_pkg::SFCD_DAT)
      serial_data_lane_oe = (nb == 3'h4) ? 4'hf : (nb == 3'h2) ? 4'h3 : 4'h1;
    else if (st_q.st == sfcd_pkg::SFCD_DAT && !st_q.rd)
      serial_data_lane_oe = (nb == 3'h4) ? 4'hf : (nb == 3'h2) ? 4'h3 : 4'h1;
  end

  // frame sequencer
  always_comb begin
    st_d = st_q;
    st_d.push = 1'b0;
    // serial clock stalls while a read has nowhere to put its byte
    if (sel_n) begin
      st_d.div = 4'h0;
      st_d.sck = 1'b0;
    end else if (!(st_q.st == sfcd_pkg::SFCD_DAT && st_q.rd && !fifo_ready)) begin
      st_d.div = (st_q.div == 4'(CLK_HALF - 1)) ? 4'h0 : st_q.div + 4'h1;
      if (st_q.div == 4'(CLK_HALF - 1)) st_d.sck = !st_q.sck;
    end
    case (st_q.st)
      sfcd_pkg::SFCD_IDLE: begin
        if (cmd_valid) begin
          st_d.op     = cmd_opcode;
          st_d.abytes = fn_addr_bytes(cmd_opcode);
          st_d.rd     = fn_is_read(cmd_opcode);
          st_d.dum    = fn_dummy(cmd_opcode, cmd_dummy);
          // freeze read only exists single-lane
          st_d.plane  = (cmd_opcode == `SFCD_OP_RD_FREEZE) ? `SFCD_LANES1 : cmd_proto;
          st_d.dlane  = (cmd_opcode == `SFCD_OP_RD_FREEZE) ? `SFCD_LANES1 : cmd_lanes;
          st_d.len    = (cmd_opcode == `SFCD_OP_WR_VLOCK) ? 16'h0001 : cmd_len;
          st_d.wdat   = cmd_wdata;
          st_d.sh     = {cmd_addr[31:0]};
          st_d.rxn    = 3'h0;
          st_d.rx     = 8'h00;
          if (fn_needs_wren(cmd_opcode)) begin
            st_d.st = sfcd_pkg::SFCD_WREN;
            st_d.pdat = cmd_opcode;
            st_d.sh = {`SFCD_OP_WREN, 24'h0};
          end else begin
            st_d.st = sfcd_pkg::SFCD_OPC;
            st_d.pdat = cmd_opcode;
            st_d.sh = {cmd_opcode, 24'h0};
          end
          st_d.bit_left = 6'h08;
          st_d.push = 1'b0;
        end
      end
      sfcd_pkg::SFCD_WREN, sfcd_pkg::SFCD_OPC, sfcd_pkg::SFCD_ADR: begin
        if (fall) begin
          st_d.sh = st_q.sh << nb;
          if (st_q.bit_left <= 6'(nb)) begin
            if (st_q.st == sfcd_pkg::SFCD_WREN) st_d.st = sfcd_pkg::SFCD_GAP;
            else if (st_q.st == sfcd_pkg::SFCD_OPC && st_q.abytes != 3'h0) begin
              st_d.st = sfcd_pkg::SFCD_ADR;
              st_d.sh = (st_q.abytes == `SFCD_ADDR4) ? addr_q : {addr_q[23:0], 8'h00};
              st_d.bit_left = {st_q.abytes, 3'h0};
            end else if (st_q.dum != 5'h0) st_d.st = sfcd_pkg::SFCD_DUM;
            else if (st_q.rd || st_q.len != 16'h0) begin
              st_d.st = sfcd_pkg::SFCD_DAT;
              st_d.sh = {st_q.wdat, 24'h0};
              st_d.bit_left = 6'h08;
            end else st_d.st = sfcd_pkg::SFCD_IDLE;
          end else st_d.bit_left = st_q.bit_left - 6'(nb);
        end
      end
      sfcd_pkg::SFCD_GAP: begin
        st_d.st = sfcd_pkg::SFCD_OPC; // deselect between frames
        st_d.sh = {st_q.op, 24'h0}; // reload the real opcode
        st_d.bit_left = 6'h08;
      end
      sfcd_pkg::SFCD_DUM: begin
        if (fall) begin
          st_d.dum = st_q.dum - 5'h1;
          if (st_q.dum == 5'h1) begin
            st_d.st = sfcd_pkg::SFCD_DAT;
            st_d.sh = {st_q.wdat, 24'h0};
            st_d.bit_left = 6'h08;
          end
        end
      end
      sfcd_pkg::SFCD_DAT: begin
        if (st_q.rd && fall && fifo_ready) begin
          // gather read bits late in the high phase, past the two sync flops
          case (nb)
            3'h4: st_d.rx = {st_q.rx[3:0], lane_s2_q};
            3'h2: st_d.rx = {st_q.rx[5:0], lane_s2_q[1:0]};
            default: st_d.rx = {st_q.rx[6:0], lane_s2_q[1]};
          endcase
          st_d.rxn = st_q.rxn + nb;
          if (st_q.rxn + nb == 4'h8 || 4'(st_q.rxn) + 4'(nb) == 4'h8) begin
            st_d.rxn = 3'h0;
            st_d.push = 1'b1;
            st_d.len = st_q.len - 16'h1;
            if (st_q.len == 16'h1) st_d.st = sfcd_pkg::SFCD_IDLE;
          end
        end else if (!st_q.rd && fall) begin
          st_d.sh = st_q.sh << nb;
          if (st_q.bit_left <= 6'(nb)) begin
            st_d.len = st_q.len - 16'h1;
            st_d.st = sfcd_pkg::SFCD_IDLE; // single data byte
          end else st_d.bit_left = st_q.bit_left - 6'(nb);
        end
      end
      default: st_d.st = sfcd_pkg::SFCD_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q    <= '0;
      st_q.st <= sfcd_pkg::SFCD_IDLE;
      addr_q  <= 32'h0;
    end else begin
      st_q <= st_d;
      if (cmd_valid && cmd_ready) addr_q <= cmd_addr;
    end
  end

  // frame shape checks
  sequence s_wren_done;
    st_q.st == sfcd_pkg::SFCD_WREN ##1 st_q.st == sfcd_pkg::SFCD_GAP;
  endsequence
  sequence s_opc_again;
    sel_n ##1 (st_q.st == sfcd_pkg::SFCD_OPC && !sel_n && st_q.sh[31:24] == st_q.op);
  endsequence
  a_wren_first: assert property (@(posedge clk_sys) disable iff (rst)
    (cmd_valid && cmd_ready && fn_needs_wren(cmd_opcode)) |=>
    (st_q.st == sfcd_pkg::SFCD_WREN && st_q.sh[31:24] == `SFCD_OP_WREN))
    else $error("write-class frame without write enable first");
  a_wren_gap: assert property (@(posedge clk_sys) disable iff (rst)
    s_wren_done |-> s_opc_again)
    else $error("no deselect or wrong opcode after write enable");
  a_fixed_dummy: assert property (@(posedge clk_sys) disable iff (rst)
    (cmd_valid && cmd_ready &&
     (cmd_opcode == `SFCD_OP_RD_GPREG || cmd_opcode == `SFCD_OP_RD_DISC)) |=>
    (st_q.dum == `SFCD_FIXED_DUMMY))
    else $error("fixed dummy count not used");
  a_lock_shape: assert property (@(posedge clk_sys) disable iff (rst)
    (cmd_valid && cmd_ready && (cmd_opcode == `SFCD_OP_RD_NVLOCK ||
     cmd_opcode == `SFCD_OP_WR_NVLOCK)) |=> (st_q.dum == 5'h00 && st_q.abytes == `SFCD_ADDR4))
    else $error("lock frame shape wrong");
  a_opcode_only: assert property (@(posedge clk_sys) disable iff (rst)
    (cmd_valid && cmd_ready && (cmd_opcode == `SFCD_OP_WAKE ||
     cmd_opcode == `SFCD_OP_SUSPEND || cmd_opcode == `SFCD_OP_RESUME)) |=>
    (st_q.dum == 5'h00 && st_q.abytes == 3'h0 && !st_q.rd))
    else $error("opcode-only frame has extra phases");
  a_freeze_single: assert property (@(posedge clk_sys) disable iff (rst)
    (st_q.st == sfcd_pkg::SFCD_OPC && st_q.op == `SFCD_OP_RD_FREEZE) |-> (nb == 3'h1))
    else $error("freeze read not single lane");
  a_idle_pins: assert property (@(posedge clk_sys) disable iff (rst)
    (st_q.st == sfcd_pkg::SFCD_IDLE) |-> (sel_n && !sck && serial_data_lane_oe == 4'h0))
    else $error("pins not idle between frames");
  a_sck_rise: assert property (@(posedge clk_sys) disable iff (rst)
    (rise && !sel_n) |=> sck)
    else $error("serial clock missed its rise");

  // read data fifo; a full fifo holds off the sampling step
  sfcd_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
    .clk       (clk_sys),
    .rst       (rst),
    .in_valid  (st_q.push),
    .in_ready  (fifo_ready),
    .in_data   (st_q.rx),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );
endmodule // sfcd_host

/* sfcd_flash_model.sv */
`timescale 1ns/100ps
// flash on the far side: extended single-lane framing, mode 0
module sfcd_flash_model #(
  parameter int DUMMY_CFG = 10
) (
  // flash pins
  input  wire logic       sel_n,
  input  wire logic       sck,
  input  wire logic [3:0] lane_o,
  input  wire logic [3:0] lane_oe,
  output logic [3:0]      lane_i,
  // frame log
  output logic [7:0]      op,
  output logic [31:0]     adr,
  output logic [7:0]      wbyte,
  output int              frames = 0,
  output int              viol = 0
);
  logic [31:0] sh;
  logic [7:0]  b;
  logic        wel = 0, drv = 0, dout = 0;
  int          n = 0, j;
  // address bytes per opcode
  function automatic int na(input logic [7:0] o);
    if (o inside {8'he2, 8'he3}) return 4;
    return (o inside {8'he8, 8'he5, 8'h5a, 8'h0b}) ? 3 : 0;
  endfunction
  // header clocks: opcode, address, fixed or configured dummy
  function automatic int hdr(input logic [7:0] o);
    if (o inside {8'h96, 8'h5a}) return 8 + 8 * na(o) + 8;
    return 8 + 8 * na(o) + ((o == 8'h0b) ? DUMMY_CFG : 0);
  endfunction
  // content of read byte k
  function automatic logic [7:0] dat(input logic [7:0] o, input logic [31:0] a, input int k);
    if (o == 8'h96) return (k < 64) ? 8'ha0 ^ k[7:0] : 8'h00;
    return a[7:0] + k[7:0] ^ o;
  endfunction
  // bits sampled on sck rises, opcode on lane 0
  always @(posedge sck or posedge sel_n) begin
    if (sel_n) begin
      n = 0;
    end else begin
      sh = {sh[30:0], lane_o[0]};
      n = n + 1;
      if (n == 8) begin
        op = sh[7:0];
        adr = 32'h0;
      end
      if (n > 8 && n == 8 + 8 * na(op)) adr = (na(op) == 4) ? sh : {8'h00, sh[23:0]};
      if (n == 16 + 8 * na(op)) wbyte = sh[7:0];
    end
  end
  // read data shifted out on sck falls, msb first; unknown opcodes get nothing
  always @(negedge sck or posedge sel_n) begin
    if (sel_n) begin
      drv = 0;
    end else if (n >= hdr(op) && op inside {8'he8, 8'he2, 8'ha7, 8'h96, 8'h5a, 8'h0b}) begin
      j = n - hdr(op);
      b = dat(op, adr, j / 8);
      drv = 1;
      dout = b[7 - j % 8];
    end
  end
  // released lanes show the inverse of the last bit, except lane 1, which carries the bit itself while driving
  always_comb begin
    for (int k = 0; k < 4; k++) lane_i[k] = lane_oe[k] ? lane_o[k] : (drv && k == 1) ? dout : ~dout;
  end
  // frame end: write enable latch and its prerequisite
  always @(posedge sel_n) begin
    frames = frames + 1;
    if (op == 8'h06) begin
      wel = 1;
    end else begin
      if (op inside {8'he5, 8'he3, 8'he4, 8'ha6, 8'hc7, 8'h60} && !wel) viol = viol + 1;
      wel = 0;
    end
  end
endmodule // sfcd_flash_model

/* serial_flash_command_decoder_tb_top.sv */
`timescale 1ns/100ps
// bench: drives the user port, checks read data and the frame log
module serial_flash_command_decoder_tb_top;
  logic        clk_sys = 0, clk_link = 0, rst = 1, cmd_valid = 0, rd_ready = 0;
  logic        cmd_ready, rd_valid, busy, sel_n, sck;
  logic [7:0]  cmd_opcode = 8'h00, cmd_wdata = 8'h00, rd_data, op, wbyte;
  logic [31:0] cmd_addr = 32'h0, adr, rng = 32'h7;
  logic [4:0]  cmd_dummy = 5'h00;
  logic [15:0] cmd_len = 16'h0;
  logic [3:0]  lo, loe, li;
  int          frames, viol, err_total = 0, checks = 0;
  logic [7:0]  ops [15] = '{8'he8, 8'he5, 8'he2, 8'he3, 8'he4, 8'ha7, 8'ha6, 8'hab,
                            8'hc7, 8'h60, 8'h75, 8'h7a, 8'h96, 8'h5a, 8'h0b};
  // clocks
  initial forever #50 clk_sys = ~clk_sys;
  initial begin
    #17;
    forever #62.5 clk_link = ~clk_link;
  end
  sfcd_host i_sfcd_host (.clk_sys(clk_sys), .rst(rst), .clk_link(clk_link),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr),
    .cmd_proto(2'h0), .cmd_lanes(2'h0), .cmd_dummy(cmd_dummy), .cmd_len(cmd_len),
    .cmd_wdata(cmd_wdata), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .busy(busy), .sel_n(sel_n), .sck(sck), .serial_data_lane_o(lo),
    .serial_data_lane_oe(loe), .serial_data_lane_i(li));
  sfcd_flash_model i_sfcd_flash_model (.sel_n(sel_n), .sck(sck), .lane_o(lo), .lane_oe(loe),
    .lane_i(li), .op(op), .adr(adr), .wbyte(wbyte), .frames(frames), .viol(viol));
  // xorshift source
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // expected read byte k
  function automatic logic [7:0] dat(input logic [7:0] o, input logic [31:0] a, input int k);
    if (o == 8'h96) return (k < 64) ? 8'ha0 ^ k[7:0] : 8'h00;
    return a[7:0] + k[7:0] ^ o;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one command: issue, drain the stream, compare with the model's log
  task automatic run(input logic [7:0] o, input logic [31:0] a, input logic [4:0] d,
                     input int len, input bit stall);
    int f0, got, w, na;
    logic [31:0] ea;
    na = (o inside {8'he2, 8'he3}) ? 4 : (o inside {8'he8, 8'he5, 8'h5a, 8'h0b}) ? 3 : 0;
    ea = (na == 4) ? a : (na == 3) ? {8'h00, a[23:0]} : 32'h0;
    f0 = frames;
    got = 0;
    w = 0;
    @(negedge clk_sys);
    cmd_opcode = o;
    cmd_addr = a;
    cmd_dummy = d;
    cmd_len = len[15:0];
    cmd_wdata = a[15:8];
    cmd_valid = 1;
    do @(posedge clk_sys); while (cmd_ready !== 1'b1 && w++ < 5000);
    @(negedge clk_sys);
    cmd_valid = 0;
    while ((busy !== 1'b0 || got < len) && w++ < 20000) begin
      @(negedge clk_sys);
      rng = xs(rng);
      rd_ready = !(stall && busy === 1'b1) && rng[0];
      // this handshake completes at the next rising edge
      if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
        chk(32'(rd_data), 32'(dat(o, ea, got)), "read byte");
        got++;
      end
    end
    chk(got, len, "byte count");
    chk(op, o, "opcode");
    chk(frames - f0, (o inside {8'he5, 8'he3, 8'he4, 8'ha6, 8'hc7, 8'h60}) ? 2 : 1, "frames");
    chk(viol, 0, "write enable");
    if (na > 0) chk(adr, ea, "address");
    if (o == 8'he5) chk(32'(wbyte), 32'(a[15:8]), "write byte");
    $display("test op %h len %0d done", o, len);
  endtask
  // watchdog
  initial begin
    #4000000;
    err_total++;
    tally_and_finish;
  end
  // main sequence
  initial begin
    int k;
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 0;
    run(8'he8, 32'h00123456, 5'h1f, 32, 1);
    run(8'h96, 32'h0, 5'h03, 70, 0);
    for (int i = 0; i < 21; i++) begin
      rng = xs(rng);
      k = (i < 15) ? i : rng % 15;
      run(ops[k], rng, (k == 14) ? 5'h0a : rng[12:8],
          (ops[k] inside {8'he8, 8'he2, 8'ha7, 8'h96, 8'h5a, 8'h0b}) ? 1 + rng[18:16] : 0, 0);
    end
    tally_and_finish;
  end
endmodule // serial_flash_command_decoder_tb_top
